// ==== logic/spc_top.sv ====
// Functional notes
// R1: Each port runs as master or slave
// R2: Two independent ports; fast master serial clock
// R3: DMA requests for transmit fill, receive drain
// R4: 64-entry 16-bit transmit and receive FIFOs
// R5: Hardware or software driven slave select
// R6: Run-time bit rate, used only as master
// R7: Item size programmable from 4 to 16
// R8: Programmable clock polarity and phase
// R9: Programmable receive sample delay as master
// R10: Separate mask bit per interrupt source
// R11: MSB first, select held whole item
`timescale 1ns/10ps
`default_nettype none

module spc_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr,
  input wire logic rd,
  input wire logic [2:0] idx,
  input wire logic [15:0] wdata,
  output logic [15:0] rd_val,
  output logic irq,
  output logic dma_tx_req,
  input wire logic dma_tx_wr,
  input wire logic [15:0] dma_tx_data,
  output logic dma_rx_req,
  input wire logic dma_rx_rd,
  output logic [15:0] dma_rx_data,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe
);
  logic [15:0] ctrl; // Mode and format
  logic [15:0] div; // Half period minus one
  logic [15:0] imask; // Interrupt enables
  logic [spc_pkg::NEV-1:0] istat; // Sticky events
  logic [15:0] tmem [spc_pkg::DEPTH]; // Transmit storage
  logic [15:0] rmem [spc_pkg::DEPTH]; // Receive storage
  logic [spc_pkg::PW:0] twp, trp, rwp, rrp; // FIFO pointers
  logic [spc_pkg::PW:0] tcnt, rcnt; // FIFO levels
  logic tempty, tfull, rempty, rfull;
  logic tpush, tpop, rpush, rpop;
  logic [2:0] sck_s, ss_s, sd_s; // Pin synchronisers
  logic ss_act; // Synced select low
  spc_pkg::spc_state_t state;
  logic sck_r; // Generated serial clock
  logic [7:0] hcnt; // Half period counter
  logic [5:0] ecnt; // Clock edges in item, up to 32
  logic [4:0] rxc; // Bits captured
  logic [4:0] n; // Bits per item
  logic [15:0] tsh, rsh; // Shift registers
  logic [15:0] rmask; // Item width mask
  logic [4:0] dl; // Delayed sample strobes
  logic en, mst, cpol, cpha;
  logic m_edge, m_lead, s_edge, s_lead, edge_p, lead, trail;
  logic samp, launch, cap, start, done;
  logic [spc_pkg::NEV-1:0] ev;

  // Control field decode
  assign en = ctrl[spc_pkg::C_EN];
  assign mst = ctrl[spc_pkg::C_MST]; // R1
  assign cpol = ctrl[spc_pkg::C_CPOL];
  assign cpha = ctrl[spc_pkg::C_CPHA];
  // Sizes below four are raised to four
  assign n = (ctrl[spc_pkg::C_SZ+:4] < 4'h3) ? 5'h04 : {1'b0, ctrl[spc_pkg::C_SZ+:4]} + 5'h01; // R7
  assign rmask = 16'hFFFF >> (5'h10 - n);

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= spc_pkg::CTRL_RST;
      div <= spc_pkg::DIV_RST;
      imask <= spc_pkg::MASK_RST;
    end else if (wr) begin
      case (idx)
        spc_pkg::A_CTRL: ctrl <= wdata;
        spc_pkg::A_DIV: div <= wdata; // R6
        spc_pkg::A_MASK: imask <= wdata; // R10
        default: ;
      endcase
    end
  end

  // FIFO flags from pointers
  assign tcnt = twp - trp;
  assign rcnt = rwp - rrp;
  assign tempty = (twp == trp);
  assign rempty = (rwp == rrp);
  assign tfull = tcnt[spc_pkg::PW]; // R4
  assign rfull = rcnt[spc_pkg::PW]; // R4
  // Bus write wins over a DMA write in the same cycle
  assign tpush = (wr && idx == spc_pkg::A_DATA || dma_tx_wr && ctrl[spc_pkg::C_DTX]) && !tfull; // R3
  assign rpop = (rd && idx == spc_pkg::A_DATA || dma_rx_rd && ctrl[spc_pkg::C_DRX]) && !rempty; // R3
  assign tpop = (state == spc_pkg::SPC_IDLE) && start && !tempty;
  assign rpush = done && !rfull;
  // DMA request levels
  assign dma_tx_req = ctrl[spc_pkg::C_DTX] && !tfull; // R3
  assign dma_rx_req = ctrl[spc_pkg::C_DRX] && !rempty; // R3

  // Transmit FIFO
  always_ff @(posedge clk) begin
    if (reset) begin
      twp <= '0;
      trp <= '0;
    end else begin
      if (tpush) begin
        tmem[twp[spc_pkg::PW-1:0]] <= (wr && idx == spc_pkg::A_DATA) ? wdata : dma_tx_data;
        twp <= twp + 7'h01;
      end
      if (tpop) begin
        trp <= trp + 7'h01;
      end
    end
  end

  // Receive FIFO, an item arriving when full is dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      rwp <= '0;
      rrp <= '0;
    end else begin
      if (rpush) begin
        rmem[rwp[spc_pkg::PW-1:0]] <= rsh & rmask;
        rwp <= rwp + 7'h01;
      end
      if (rpop) begin
        rrp <= rrp + 7'h01;
      end
    end
  end

  // Word handed to DMA on its pop
  always_ff @(posedge clk) begin
    if (reset) begin
      dma_rx_data <= 16'h0000;
    end else if (rpop && !(rd && idx == spc_pkg::A_DATA)) begin
      dma_rx_data <= rmem[rrp[spc_pkg::PW-1:0]];
    end
  end

  // Two-flop synchronisers; stage two and three feed edge logic
  always_ff @(posedge clk) begin
    if (reset) begin
      sck_s <= 3'h0;
      ss_s <= 3'h7;
      sd_s <= 3'h0;
    end else begin
      sck_s <= {sck_s[1:0], sclk_i};
      ss_s <= {ss_s[1:0], ss_n_i};
      sd_s <= {sd_s[1:0], sdi};
    end
  end
  assign ss_act = !ss_s[1];

  // Master clock divider, idles at the chosen polarity
  always_ff @(posedge clk) begin
    if (reset) begin
      hcnt <= 8'h00;
      sck_r <= 1'b0;
    end else if (!(mst && state == spc_pkg::SPC_RUN)) begin
      hcnt <= 8'h00;
      sck_r <= cpol; // R8
    end else if (ecnt < {n, 1'b0}) begin
      if (hcnt >= div[7:0]) begin
        hcnt <= 8'h00;
        sck_r <= !sck_r; // R6
      end else begin
        hcnt <= hcnt + 8'h01;
      end
    end
  end

  // Edge pulses, from the divider as master or the pin as slave
  assign m_edge = mst && state == spc_pkg::SPC_RUN && ecnt < {n, 1'b0} && hcnt >= div[7:0];
  assign m_lead = m_edge && (sck_r == cpol);
  assign s_edge = !mst && state == spc_pkg::SPC_RUN && (sck_s[1] != sck_s[2]);
  assign s_lead = s_edge && (sck_s[1] != cpol);
  assign edge_p = m_edge || s_edge;
  assign lead = m_lead || s_lead;
  assign trail = edge_p && !lead;
  // Phase picks which edge samples and which launches
  assign samp = cpha ? trail : lead; // R8
  assign launch = cpha ? lead : trail; // R8

  // Sample strobe delay line for master mode
  always_ff @(posedge clk) begin
    if (reset) begin
      dl <= 5'h00;
    end else begin
      dl <= {dl[3:0], samp && mst};
    end
  end
  // Two base clocks line the strobe up with the data synchroniser
  assign cap = mst ? dl[3'h1 + {1'b0, ctrl[spc_pkg::C_DLY+:2]}] : samp; // R9

  // Start and end of an item
  assign start = en && (mst ? !tempty : ss_act); // R1
  assign done = (state == spc_pkg::SPC_RUN) && (rxc == n) && (!mst || ecnt == {n, 1'b0});

  // Shift engine
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= spc_pkg::SPC_IDLE;
      tsh <= 16'h0000;
      rsh <= 16'h0000;
      ecnt <= 6'h00;
      rxc <= 5'h00;
    end else begin
      case (state)
        spc_pkg::SPC_IDLE: begin
          ecnt <= 6'h00;
          rxc <= 5'h00;
          if (start) begin
            // Left justify so the top bit goes first
            tsh <= (tempty ? 16'h0000 : tmem[trp[spc_pkg::PW-1:0]]) << (5'h10 - n); // R11
            state <= spc_pkg::SPC_RUN;
          end
        end
        spc_pkg::SPC_RUN: begin
          if (edge_p) begin
            ecnt <= ecnt + 6'h01;
          end
          // First launch of phase one shows the preloaded bit
          if (launch && !(cpha && ecnt == 6'h00)) begin
            tsh <= {tsh[14:0], 1'b0}; // R11
          end
          if (cap && rxc < n) begin
            rsh <= {rsh[14:0], sd_s[1]}; // R11
            rxc <= rxc + 5'h01;
          end
          if (done) begin
            state <= spc_pkg::SPC_IDLE;
          end else if (!mst && !ss_act) begin
            // Slave select lost mid item: abandon it
            state <= spc_pkg::SPC_IDLE;
          end else if (!en) begin
            state <= spc_pkg::SPC_IDLE;
          end
        end
        default: state <= spc_pkg::SPC_IDLE;
      endcase
    end
  end

  // Pin drive
  assign sclk_o = sck_r;
  assign sdo = tsh[15]; // R11
  assign sclk_oe = en && mst; // R1
  assign ss_n_oe = en && mst;
  // Select follows the item or the software bit
  assign ss_n_o = ctrl[spc_pkg::C_SWSS] ? ctrl[spc_pkg::C_SSV] : (state != spc_pkg::SPC_RUN); // R5 R11
  assign sdo_oe = en && (mst || ss_act);

  // Event sources
  assign ev[spc_pkg::E_TXE] = tpop && tcnt == 7'h01;
  assign ev[spc_pkg::E_RXA] = rpush;
  assign ev[spc_pkg::E_ROV] = done && rfull;
  assign ev[spc_pkg::E_TUN] = (state == spc_pkg::SPC_IDLE) && start && tempty;
  assign ev[spc_pkg::E_DONE] = done;

  // Sticky status, cleared by its read; a new event wins
  always_ff @(posedge clk) begin
    if (reset) begin
      istat <= '0;
    end else begin
      istat <= (istat & ~{spc_pkg::NEV{rd && idx == spc_pkg::A_INT}}) | ev;
    end
  end
  assign irq = |(istat & imask[spc_pkg::NEV-1:0]); // R10

  // Read value mux
  always_comb begin
    rd_val = 16'h0000;
    case (idx)
      spc_pkg::A_CTRL: rd_val = ctrl;
      spc_pkg::A_DIV: rd_val = div;
      spc_pkg::A_DATA: rd_val = rempty ? 16'h0000 : rmem[rrp[spc_pkg::PW-1:0]];
      spc_pkg::A_STAT: rd_val = {1'b0, rcnt, 3'h0, state == spc_pkg::SPC_RUN, rfull, rempty, tfull, tempty};
      spc_pkg::A_INT: rd_val = {11'h000, istat};
      spc_pkg::A_MASK: rd_val = imask;
      default: rd_val = 16'h0000;
    endcase
  end
endmodule

module spc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  output logic [1:0] dma_tx_req,
  input wire logic [1:0] dma_tx_wr,
  input wire logic [1:0][15:0] dma_tx_data,
  output logic [1:0] dma_rx_req,
  input wire logic [1:0] dma_rx_rd,
  output logic [1:0][15:0] dma_rx_data,
  input wire logic [1:0] sclk_i,
  output logic [1:0] sclk_o,
  output logic [1:0] sclk_oe,
  input wire logic [1:0] ss_n_i,
  output logic [1:0] ss_n_o,
  output logic [1:0] ss_n_oe,
  input wire logic [1:0] sdi,
  output logic [1:0] sdo,
  output logic [1:0] sdo_oe
);
  logic [15:0] pval [spc_pkg::NPORT]; // Per port read values
  logic [1:0] pirq; // Per port interrupts
  logic hit; // Mapped register address

  assign hit = addr[7:6] == 2'h0 && addr[1:0] == 2'h0 && addr[4:2] <= spc_pkg::A_MASK;

  // Two identical ports
  for (genvar g = 0; g < spc_pkg::NPORT; g++) begin : g_port
    spc_port u_port ( // R2
      .clk(clk),
      .reset(reset),
      .wr(wr && hit && addr[spc_pkg::PORT_BIT] == g),
      .rd(rd && hit && addr[spc_pkg::PORT_BIT] == g),
      .idx(addr[4:2]),
      .wdata(wdata[15:0]),
      .rd_val(pval[g]),
      .irq(pirq[g]),
      .dma_tx_req(dma_tx_req[g]),
      .dma_tx_wr(dma_tx_wr[g]),
      .dma_tx_data(dma_tx_data[g]),
      .dma_rx_req(dma_rx_req[g]),
      .dma_rx_rd(dma_rx_rd[g]),
      .dma_rx_data(dma_rx_data[g]),
      .sclk_i(sclk_i[g]),
      .sclk_o(sclk_o[g]),
      .sclk_oe(sclk_oe[g]),
      .ss_n_i(ss_n_i[g]),
      .ss_n_o(ss_n_o[g]),
      .ss_n_oe(ss_n_oe[g]),
      .sdi(sdi[g]),
      .sdo(sdo[g]),
      .sdo_oe(sdo_oe[g])
    );
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rd && hit) begin
      rdata <= {16'h0000, pval[addr[spc_pkg::PORT_BIT]]};
    end else begin
      rdata <= 32'h00000000;
    end
  end

  assign irq = |pirq;
endmodule

`default_nettype wire

// ==== shared/spc_pkg.sv ====
// Shared constants for the dual serial port controller
package spc_pkg;
  // System clock and fastest link rate
  localparam int CLK_HZ = 40_000_000;
  localparam int SCLK_MAX_HZ = 25_000_000;
  // Least half period of the generated serial clock, rounded up
  localparam int MIN_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  // Data and FIFO geometry
  localparam int DW = 16;
  localparam int DEPTH = 64;
  localparam int PW = 6;
  localparam int NPORT = 2;
  // Address layout: bit 5 picks the port, bits 4:2 the register
  localparam int PORT_BIT = 5;
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_DIV = 3'h1;
  localparam logic [2:0] A_DATA = 3'h2;
  localparam logic [2:0] A_STAT = 3'h3;
  localparam logic [2:0] A_INT = 3'h4;
  localparam logic [2:0] A_MASK = 3'h5;
  // Control register fields
  localparam int C_EN = 0;
  localparam int C_MST = 1;
  localparam int C_CPOL = 2;
  localparam int C_CPHA = 3;
  localparam int C_SZ = 4;
  localparam int C_SWSS = 8;
  localparam int C_SSV = 9;
  localparam int C_DLY = 10;
  localparam int C_DTX = 12;
  localparam int C_DRX = 13;
  // Reset values: 8-bit items, half period of two clocks
  localparam logic [15:0] CTRL_RST = 16'h0270;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [15:0] MASK_RST = 16'h0000;
  // Interrupt event bits
  localparam int E_TXE = 0;
  localparam int E_RXA = 1;
  localparam int E_ROV = 2;
  localparam int E_TUN = 3;
  localparam int E_DONE = 4;
  localparam int NEV = 5;
  // Shift engine states
  typedef enum logic [0:0] {SPC_IDLE, SPC_RUN} spc_state_t;
endpackage

// ==== tb/spc_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// Pin-level checks on the controller top
module spc_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic [1:0] dma_tx_req,
  input wire logic [1:0] dma_rx_req,
  input wire logic [1:0] dma_rx_rd,
  input wire logic [1:0][15:0] dma_rx_data,
  input wire logic [1:0] sclk_o,
  input wire logic [1:0] sclk_oe,
  input wire logic [1:0] ss_n_i,
  input wire logic [1:0] ss_n_o,
  input wire logic [1:0] ss_n_oe,
  input wire logic [1:0] sdo_oe
);
  // Single domain, synchronous reset
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Quiet pins right after reset
  a_reset_quiet: assert property ($fell(reset) |-> !irq && dma_tx_req == 2'h0 && dma_rx_req == 2'h0
    && ss_n_o == 2'h3 && sclk_oe == 2'h0 && sdo_oe == 2'h0) else $error("busy after reset");
  // Clock and select drivers switch together
  a_oe_pair: assert property (sclk_oe == ss_n_oe) else $error("enable mismatch");
  // Select stays low for at least eight cycles once it falls
  a_ss_hold: assert property ($fell(ss_n_o[0]) && sclk_oe[0] |-> !ss_n_o[0] [*8]) else $error("select short");
  // Clock only moves inside a frame
  a_clk_frame: assert property (
    sclk_oe[0] && $past(sclk_oe[0]) && $changed(sclk_o[0]) |-> !ss_n_o[0]) else $error("clock outside frame");
  // Slave drives data only while selected
  a_slave_drive: assert property (
    sdo_oe[1] && !sclk_oe[1] |-> !$past(ss_n_i[1]) || !$past(ss_n_i[1], 2) || !$past(ss_n_i[1], 3))
    else $error("slave drives unselected");
  // DMA word holds until the next pop
  a_dma_hold: assert property (!$past(dma_rx_rd[0]) |-> $stable(dma_rx_data[0])) else $error("dma word moved");
  // Read data only in the slot after a read
  a_rdata_slot: assert property (!$past(rd) |-> rdata == 32'h0) else $error("stray read data");
  // Entries are 16 bits wide
  a_rdata_high: assert property (rdata[31:16] == 16'h0) else $error("upper read data set");
endmodule
bind spc_top spc_chk u_chk (.clk, .reset, .rd, .rdata, .irq, .dma_tx_req, .dma_rx_req, .dma_rx_rd,
  .dma_rx_data, .sclk_o, .sclk_oe, .ss_n_i, .ss_n_o, .ss_n_oe, .sdo_oe);
`default_nettype wire

// ==== tb/spc_peer.sv ====
`timescale 1ns/10ps
`default_nettype none
// Serial slave on the far side of port 0
module spc_peer (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [1:0] mode,
  input wire logic [15:0] reply,
  input wire logic [4:0] nbits,
  output logic miso,
  output logic [15:0] got
);
  int cnt; // Bits sampled this frame
  initial miso = 1'b0;
  // Frame start: phase 0 shows the first bit at once
  always @(negedge ss_n) begin
    cnt = 0;
    got = 16'h0000;
    if (!mode[0]) miso = reply[nbits - 1];
  end
  // Sample on one edge kind, launch on the other
  always @(sclk) begin
    if (!ss_n && ((sclk != mode[1]) ^ mode[0])) begin
      got = {got[14:0], mosi};
      cnt++;
    end else if (!ss_n) begin
      miso = (cnt < nbits) ? reply[nbits - 1 - cnt] : ~miso;
    end
  end
  // A released line shows the inverse of its last bit
  always @(posedge ss_n) miso = ~miso;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Bench for the dual port controller
module tb_top;
  logic clk = 0, reset = 1, wr = 0, rd = 0, irq, miso, sdi1 = 0;
  logic [7:0] addr = 8'h00, q;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] dma_tx_req, dma_rx_req, sclk_o, sclk_oe, ss_n_o, ss_n_oe, sdo, sdo_oe, sdi, pmode = 2'h0;
  logic [1:0] dma_tx_wr = 2'h0, dma_rx_rd = 2'h0, sclk_i = 2'h0, ss_n_i = 2'h3;
  logic [1:0][15:0] dma_tx_data = '0, dma_rx_data;
  logic [15:0] rep = 16'h0, got, w, m;
  logic [4:0] nb = 5'h8;
  int err_count = 0, checked = 0, cyc = 0, k, dv, sz, dl;
  assign sdi = {sdi1, miso};
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  spc_top u_spc_top (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .irq, .dma_tx_req, .dma_tx_wr,
    .dma_tx_data, .dma_rx_req, .dma_rx_rd, .dma_rx_data, .sclk_i, .sclk_o, .sclk_oe, .ss_n_i, .ss_n_o,
    .ss_n_oe, .sdi, .sdo, .sdo_oe);
  spc_peer u_peer (.sclk(sclk_o[0]), .ss_n(ss_n_o[0]), .mosi(sdo[0]), .mode(pmode), .reply(rep),
    .nbits(nb), .miso(miso), .got(got));
  // Verdict and end of run
  task summarize;
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Compare one value
  task chk(input logic [15:0] e, input logic [15:0] a);
    checked++;
    if (a !== e) begin
      $display("FAIL %0t got %h want %h", $time, a, e);
      err_count++;
    end
  endtask
  // Register write
  task wreg(input int p, input int x, input logic [15:0] d);
    @(posedge clk);
    addr <= 8'({p[0], x[2:0], 2'b00});
    wdata <= {16'h0, d};
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  // Register read, compared one cycle later
  task rchk(input int p, input int x, input logic [15:0] e);
    @(posedge clk);
    addr <= 8'({p[0], x[2:0], 2'b00});
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    chk(e, rdata[15:0]);
  endtask
  // Reprogram port 0 while disabled, then enable
  task cfg(input logic [15:0] c);
    wreg(0, 0, c & 16'hFFFE);
    wreg(0, 0, c);
  endtask
  // Wait for one frame of port 0 to open and close
  task frame;
    int n;
    for (n = 0; n < 400 && ss_n_o[0] !== 1'b0; n++) @(posedge clk) #1;
    for (n = 0; n < 400 && ss_n_o[0] !== 1'b1; n++) @(posedge clk) #1;
    repeat (2) @(posedge clk);
  endtask
  // One mode 0 frame into port 1, 200 ns link clock
  task slv(input logic [7:0] b);
    int n;
    #7 ss_n_i[1] <= 0;
    for (n = 7; n >= 0; n--) begin
      sdi1 <= b[n];
      #100 sclk_i[1] <= 1;
      q[n] = sdo[1];
      #100 sclk_i[1] <= 0;
    end
    #100 ss_n_i[1] <= 1;
    sdi1 <= ~sdi1;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(42816));
    repeat (3) @(posedge clk);
    reset <= 0;
    rchk(0, 0, spc_pkg::CTRL_RST);
    rchk(1, 1, spc_pkg::DIV_RST);
    rchk(0, 5, spc_pkg::MASK_RST);
    rchk(1, 7, 16'h0000);
    // All four clock modes, sizes and rates at random
    for (k = 0; k < 8; k++) begin
      dv = (k == 0) ? 0 : $urandom % 4;
      sz = (k < 2) ? 3 + 12 * k : 3 + $urandom % 13;
      dl = $urandom % (dv + 1);
      pmode <= {k[0], k[1]};
      nb <= 5'(sz + 1);
      rep <= 16'($urandom);
      w = 16'($urandom);
      m = 16'((17'h1 << (sz + 1)) - 1);
      wreg(0, 1, 16'(dv));
      cfg(16'(3 | k % 4 << 2 | sz << 4 | dl << 10));
      chk(16'(k[0]), 16'(sclk_o[0]));
      wreg(0, 2, w);
      frame();
      chk(w & m, got);
      rchk(0, 2, rep & m);
    end
    // Back-to-back items and the interrupt path
    rchk(0, 4, 16'h0013);
    pmode <= 2'h0;
    nb <= 5'h8;
    cfg(16'h0073);
    wreg(0, 2, w);
    wreg(0, 2, ~w);
    frame();
    frame();
    chk(~w & 16'h00FF, got);
    chk(16'h0, 16'(irq));
    wreg(0, 5, 16'h0010);
    chk(16'h1, 16'(irq));
    rchk(0, 4, 16'h0013);
    chk(16'h0, 16'(irq));
    rchk(0, 2, rep & 16'h00FF);
    rchk(0, 2, rep & 16'h00FF);
    rchk(0, 3, 16'h0005);
    // DMA fill and drain
    cfg(16'h3073);
    chk(16'h1, 16'(dma_tx_req[0]));
    @(posedge clk);
    dma_tx_wr[0] <= 1;
    dma_tx_data[0] <= w;
    @(posedge clk);
    dma_tx_wr[0] <= 0;
    frame();
    chk(16'h1, 16'(dma_rx_req[0]));
    @(posedge clk);
    dma_rx_rd[0] <= 1;
    @(posedge clk);
    dma_rx_rd[0] <= 0;
    #1;
    chk(rep & 16'h00FF, dma_rx_data[0]);
    chk(16'h0, 16'(dma_rx_req[0]));
    chk(w & 16'h00FF, got);
    // Software select line
    wreg(0, 0, 16'h0100);
    rchk(0, 0, 16'h0100);
    chk(16'h0, 16'(ss_n_o[0]));
    wreg(0, 0, 16'h0300);
    rchk(0, 0, 16'h0300);
    chk(16'h1, 16'(ss_n_o[0]));
    // Port 1 as slave to an outside master
    wreg(1, 0, 16'h0071);
    wreg(1, 2, w);
    slv(rep[7:0]);
    chk(w & 16'h00FF, {8'h00, q});
    rchk(1, 2, rep & 16'h00FF);
    summarize();
  end
endmodule
`default_nettype wire
